// >>> inc/pulse_seq_pkg.sv
// Purpose: Shared constants for the pulse program sequencer
// Assumes: Wishbone classic slave, 32-bit data, 250 MHz core clock
// Notes: Instruction words are written in three register slices, then committed
package pulse_seq_pkg;
    localparam int ADDR_W = 10;
    localparam int DEPTH = 1024;
    localparam int PAT_W = 24;
    localparam int DELAY_W = 32;
    localparam int DATA_W = 21;
    localparam int OP_W = 4;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LOAD_ADDR = 8'h08;
    localparam logic [7:0] REG_INST_PAT = 8'h0C;
    localparam logic [7:0] REG_INST_OP = 8'h10;
    localparam logic [7:0] REG_INST_DELAY = 8'h14;
    localparam logic [7:0] REG_INST_COMMIT = 8'h18;
    localparam logic [7:0] REG_CONFIG = 8'h1C;
    // Control bits (write one to act)
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_RESET = 2;
    localparam int CTRL_PROG_BEGIN = 3;
    localparam int CTRL_PROG_END = 4;
    localparam int CTRL_TRIGGER = 5;
    // Status bits
    localparam int ST_STOPPED = 0;
    localparam int ST_RESET = 1;
    localparam int ST_RUNNING = 2;
    localparam int ST_WAITING = 3;
    localparam int ST_PROGRAMMING = 4;
    localparam int ST_LOADED = 5;
    // Short pulse field
    localparam int SHORT_LO = 21;
    localparam int SHORT_HI = 23;
    localparam logic [2:0] SHORT_OFF = 3'h7;
    localparam logic [2:0] TRIPLE_CYCLE_PULSE_CODE = 3'h3;
    localparam logic [1:0] TRIPLE_CYCLES = 2'h3;
    // Opcodes
    localparam logic [OP_W-1:0] OP_CONTINUE = 4'h0;
    localparam logic [OP_W-1:0] OP_STOP = 4'h1;
    localparam logic [OP_W-1:0] OP_BRANCH = 4'h6;
    localparam logic [OP_W-1:0] OP_LONG_DELAY = 4'h7;
    localparam logic [OP_W-1:0] OP_WAIT = 4'h8;
    localparam logic [DATA_W-1:0] LONG_DELAY_MAX = 21'h100000;
    localparam logic [DELAY_W-1:0] MIN_DELAY = 32'h00000002;
    localparam logic [31:0] WB_ACK_LATENCY = 32'h00000001;
    typedef enum logic [2:0] {
        ST_IDLE_S, ST_LOAD_S, ST_EXEC_S, ST_WAIT_S, ST_HALT_S
    } seq_state_type;
endpackage

// >>> rtl/pulse_program_sequencer.sv
// Purpose: Stored-program pulse sequencer driving 24 TTL outputs
// Assumes: Host writes instructions over Wishbone before starting
// Notes: Delay count is cycles per instruction, at least two
// Functional notes
// - Pattern bits drive matching outputs high
// - Field code 111 keeps full-length outputs
// - Triple-cycle code limits outputs below the field to three cycles
// - Delay counter covers about 17180 milliseconds
// - Long delay repeats delay data times
// - Continue holds pattern then advances address
// - Branch holds pattern then jumps to data
// - Instruction addresses start at zero
// - No start until loading is finished
// - Start runs program from first instruction
// - Stop halts; outputs hold or clear
// - Execution continues without host session
// - Stop opcode raises stopped status
// - Wait opcode raises waiting with running
// - Trigger falling edge resumes after wait
// - Restart input low returns to start
`timescale 1ns/10ps
`default_nettype none
module pulse_program_sequencer
    import pulse_seq_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // External pins, active low
    input wire logic external_trigger_in_n_i,
    input wire logic external_restart_in_n_i,
    // Outputs and status
    output logic [PAT_W-1:0] ttl_o,
    output logic stopped_o,
    output logic reset_state_o,
    output logic running_o,
    output logic waiting_o
);
    logic [PAT_W-1:0] pat_mem [DEPTH];
    logic [OP_W-1:0] op_mem [DEPTH];
    logic [DATA_W-1:0] data_mem [DEPTH];
    logic [DELAY_W-1:0] delay_mem [DEPTH];
    seq_state_type state;
    logic [ADDR_W-1:0] load_addr;
    logic [ADDR_W-1:0] pc;
    logic [PAT_W-1:0] stage_pat;
    logic [31:0] stage_op;
    logic [DELAY_W-1:0] stage_delay;
    logic loaded;
    logic clear_on_stop;
    logic [DELAY_W-1:0] count;
    logic [DATA_W-1:0] repeats;
    logic [1:0] short_count;
    logic [PAT_W-1:0] cur_pat;
    logic [OP_W-1:0] cur_op;
    logic [DATA_W-1:0] cur_data;
    logic trig_prev;
    logic trig_fall;
    logic wr;
    logic cmd_start;
    logic cmd_stop;
    logic cmd_reset;
    logic cmd_trig;
    logic expire;
    logic [ADDR_W-1:0] next_pc;
    logic ctrl_wr;
    logic cmd_begin;
    logic cmd_end;
    logic commit;
    logic restart;
    logic trigger;
    logic [31:0] status_word;

    assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    assign ctrl_wr = wr && adr_i == REG_CTRL;
    assign cmd_start = ctrl_wr && dat_i[CTRL_START];
    assign cmd_stop = ctrl_wr && dat_i[CTRL_STOP];
    assign cmd_reset = ctrl_wr && dat_i[CTRL_RESET];
    assign cmd_trig = ctrl_wr && dat_i[CTRL_TRIGGER];
    assign cmd_begin = ctrl_wr && dat_i[CTRL_PROG_BEGIN];
    assign cmd_end = ctrl_wr && dat_i[CTRL_PROG_END];
    assign commit = wr && adr_i == REG_INST_COMMIT && state == ST_LOAD_S;
    // Pin and command share one path, so either rescues a hung program
    assign restart = !external_restart_in_n_i || cmd_reset;
    assign trig_fall = trig_prev && !external_trigger_in_n_i;
    assign trigger = cmd_trig || trig_fall;

    // Bus answer one cycle after request, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i && stb_i && !ack_o;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h00000000;
        else if (cyc_i && stb_i && !we_i && !ack_o)
        begin
            unique case (adr_i)
                REG_STATUS:
                    dat_o <= status_word;
                REG_LOAD_ADDR:
                    dat_o <= {22'h000000, load_addr};
                REG_INST_PAT:
                    dat_o <= {8'h00, stage_pat};
                REG_INST_OP:
                    dat_o <= stage_op;
                REG_INST_DELAY:
                    dat_o <= stage_delay;
                REG_CONFIG:
                    dat_o <= {31'h00000000, clear_on_stop};
                default:
                    dat_o <= 32'h00000000;
            endcase
        end
    end

    // Staging registers and configuration
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stage_pat <= 24'h000000;
            stage_op <= 32'h00000000;
            stage_delay <= MIN_DELAY;
            clear_on_stop <= 1'b0;
        end
        else if (wr)
        begin
            if (adr_i == REG_INST_PAT)
                stage_pat <= dat_i[PAT_W-1:0];
            if (adr_i == REG_INST_OP)
                stage_op <= dat_i;
            // Host rounds and bounds the count
            if (adr_i == REG_INST_DELAY)
                stage_delay <= dat_i;
            if (adr_i == REG_CONFIG)
                clear_on_stop <= dat_i[0];
        end
    end

    // Commit only while in load mode
    always_ff @(posedge clk_i)
    begin
        if (commit)
        begin
            pat_mem[load_addr] <= stage_pat;
            op_mem[load_addr] <= stage_op[OP_W-1:0];
            data_mem[load_addr] <= stage_op[DATA_W+7:8];
            delay_mem[load_addr] <= stage_delay;
        end
    end

    // Load address restarts at zero each session
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            load_addr <= '0;
        else if (cmd_begin)
            load_addr <= '0;
        else if (wr && adr_i == REG_LOAD_ADDR)
            load_addr <= dat_i[ADDR_W-1:0];
        else if (commit)
            load_addr <= load_addr + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            trig_prev <= 1'b1;
        else
            trig_prev <= external_trigger_in_n_i;
    end

    // Start stays refused until loading is closed
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            loaded <= 1'b0;
        else if (cmd_begin && !restart)
            loaded <= 1'b0;
        else if (cmd_end && !restart && state == ST_LOAD_S)
            loaded <= 1'b1;
    end

    // Counter expiry marks instruction end
    // A count of zero ends at once instead of wrapping to a huge wait
    assign expire = count <= 32'h00000001;

    always_comb
    begin
        next_pc = pc + 1'b1;
        if (cur_op == OP_BRANCH)
            next_pc = cur_data[ADDR_W-1:0];
    end

    // Main sequencer; runs without any host traffic
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= ST_IDLE_S;
            pc <= '0;
            count <= 32'h00000000;
            repeats <= '0;
            short_count <= 2'h0;
            cur_pat <= 24'h000000;
            cur_op <= OP_CONTINUE;
            cur_data <= '0;
            ttl_o <= 24'h000000;
        end
        else if (restart)
        begin
            // Back to first instruction, idle unless loading
            state <= (state == ST_LOAD_S) ? ST_LOAD_S : ST_IDLE_S;
            pc <= '0;
            ttl_o <= 24'h000000;
        end
        else if (cmd_begin)
        begin
            state <= ST_LOAD_S;
            ttl_o <= 24'h000000;
        end
        else if (state == ST_LOAD_S)
        begin
            if (cmd_end)
            begin
                state <= ST_IDLE_S;
                pc <= '0;
            end
        end
        else if (cmd_stop && state != ST_IDLE_S)
        begin
            state <= ST_IDLE_S;
            pc <= '0;
            if (clear_on_stop)
                ttl_o <= 24'h000000;
        end
        else if (loaded && state == ST_IDLE_S &&
            (cmd_start || trigger))
        begin
            // Fetch first instruction
            cur_pat <= pat_mem[0];
            cur_op <= op_mem[0];
            cur_data <= data_mem[0];
            count <= delay_mem[0];
            repeats <= data_mem[0];
            short_count <= TRIPLE_CYCLES;
            ttl_o <= pat_mem[0];
            pc <= '0;
            state <= ST_EXEC_S;
        end
        else if (state == ST_WAIT_S)
        begin
            if (trigger)
            begin
                // Resume at next address
                cur_pat <= pat_mem[pc];
                cur_op <= op_mem[pc];
                cur_data <= data_mem[pc];
                count <= delay_mem[pc];
                repeats <= data_mem[pc];
                short_count <= TRIPLE_CYCLES;
                ttl_o <= pat_mem[pc];
                state <= ST_EXEC_S;
            end
        end
        else if (state == ST_EXEC_S)
        begin
            // Short pulse only when field is 011
            if (cur_pat[SHORT_HI:SHORT_LO] == TRIPLE_CYCLE_PULSE_CODE)
            begin
                if (short_count != 2'h0)
                    short_count <= short_count - 1'b1;
                if (short_count == 2'h1)
                    ttl_o <= {SHORT_OFF, 21'h000000} & cur_pat;
            end
            if (!expire)
                count <= count - 1'b1;
            else if (cur_op == OP_LONG_DELAY && repeats > 21'h000001)
            begin
                // Repeat the delay
                repeats <= repeats - 1'b1;
                count <= delay_mem[pc];
            end
            else if (cur_op == OP_STOP)
                state <= ST_HALT_S;
            else if (cur_op == OP_WAIT)
            begin
                pc <= pc + 1'b1;
                state <= ST_WAIT_S;
            end
            else
            begin
                // Fetch next instruction
                pc <= next_pc;
                cur_pat <= pat_mem[next_pc];
                cur_op <= op_mem[next_pc];
                cur_data <= data_mem[next_pc];
                count <= delay_mem[next_pc];
                repeats <= data_mem[next_pc];
                short_count <= TRIPLE_CYCLES;
                ttl_o <= pat_mem[next_pc];
            end
        end
    end

    // Status pins decoded from state
    always_comb
    begin
        stopped_o = state == ST_HALT_S;
        waiting_o = state == ST_WAIT_S;
        running_o = state == ST_EXEC_S || state == ST_WAIT_S;
        reset_state_o = state == ST_IDLE_S || state == ST_LOAD_S;
    end

    // Status word laid out by the named bit positions
    always_comb
    begin
        status_word = 32'h00000000;
        status_word[ST_STOPPED] = stopped_o;
        status_word[ST_RESET] = reset_state_o;
        status_word[ST_RUNNING] = running_o;
        status_word[ST_WAITING] = waiting_o;
        status_word[ST_PROGRAMMING] = state == ST_LOAD_S;
        status_word[ST_LOADED] = loaded;
    end
endmodule // pulse_program_sequencer
`default_nettype wire

// >>> testbench/host_model.sv
// Purpose: Host software model, a Wishbone master
// Assumes: Slave acks one cycle after taking a request
// Notes: Waits for ack without limit; the bench watchdog cuts hangs
`timescale 1ns/10ps
`default_nettype none
module host_model
    import pulse_seq_pkg::*;
(
    // Clock and answer
    input wire logic clk_i,
    input wire logic ack_i,
    // Request
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    integer seed = 32'h5006E3E1;
    initial
    begin
        {cyc_o, stb_o, we_o, adr_o, dat_o} = '0;
        sel_o = 4'hF;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'h3, w, a, d};
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask
    // Durations rounded to whole 4 ns periods, callers stay above 10 ns
    task automatic inst(input logic [23:0] p, input logic [3:0] op,
        input logic [20:0] d, input real ns);
        xfer(1'b1, REG_INST_PAT, {8'h00, p});
        xfer(1'b1, REG_INST_OP, {3'h0, d, 4'h0, op});
        xfer(1'b1, REG_INST_DELAY, 32'($rtoi(ns / 4.0 + 0.5)));
        xfer(1'b1, REG_INST_COMMIT, $random(seed));
    endtask
endmodule // host_model
`default_nettype wire

// >>> testbench/pulse_program_sequencer_tb.sv
// Purpose: Self-checking bench for the pulse sequencer
// Assumes: 250 MHz clock, host model drives the bus
// Notes: Top byte of a pattern note is the previous hold count, 0 free
`timescale 1ns/10ps
`default_nettype none
module pulse_program_sequencer_tb;
    import pulse_seq_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i, stb_i, we_i, ack_o, stopped_o, reset_state_o;
    logic running_o, waiting_o;
    logic external_trigger_in_n_i = 1'b1;
    logic external_restart_in_n_i = 1'b1;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic [PAT_W-1:0] ttl_o, prev;
    logic [31:0] tq[$], rq[$];
    int n_mismatch = 0, n_checks = 0, cnt = 0;
    always #2 clk_i = ~clk_i;
    pulse_program_sequencer dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
        .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .external_trigger_in_n_i,
        .external_restart_in_n_i, .ttl_o, .stopped_o, .reset_state_o,
        .running_o, .waiting_o);
    host_model host (.clk_i, .ack_i(ack_o), .cyc_o(cyc_i), .stb_o(stb_i),
        .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wt(input bit stop);
        int i;
        i = 0;
        while ((stop ? stopped_o : waiting_o) !== 1'b1 && i < 500)
        begin
            @(posedge clk_i);
            i++;
        end
        chk(32'(i < 500), 32'h1);
    endtask
    // Pattern changes and read answers are compared against the notes
    always @(posedge clk_i)
    begin
        if (!rst_i && ttl_o !== prev)
        begin
            if (tq.size() == 0)
                chk({8'h00, ttl_o}, 32'hFFFFFFFF);
            else if (tq[0][31:24] == 8'h00)
                chk({8'h00, ttl_o}, tq.pop_front());
            else
                chk({cnt[7:0], ttl_o}, tq.pop_front());
            cnt = 1;
        end
        else
            cnt++;
        prev = ttl_o;
        if (ack_o === 1'b1 && we_i === 1'b0)
            chk(dat_o, rq.size() ? rq.pop_front() : 32'hFFFFFFFF);
    end
    initial
    begin
        #40000;
        n_mismatch++;
        summarize();
    end
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        host.xfer(1'b1, REG_CTRL, 32'h01);
        rd(REG_STATUS, 32'h2);
        rd(8'h40, 32'h0);
        host.xfer(1'b1, REG_CTRL, 32'h08);
        host.inst(24'hE00010, OP_CONTINUE, 21'h0, 15.0);
        host.inst(24'h60000F, OP_CONTINUE, 21'h0, 24.0);
        host.inst(24'hE00001, OP_BRANCH, 21'h4, 12.0);
        host.inst(24'hE00FFF, OP_STOP, 21'h0, 12.0);
        host.inst(24'hE00004, OP_LONG_DELAY, 21'h2, 10.5);
        host.inst(24'hE00002, OP_WAIT, 21'h0, 11.0);
        host.inst(24'h000000, OP_STOP, 21'h0, 11.0);
        host.xfer(1'b1, REG_CTRL, 32'h01);
        rd(REG_STATUS, 32'h12);
        rd(REG_LOAD_ADDR, 32'h7);
        host.xfer(1'b1, REG_CTRL, 32'h10);
        $display("test load done");
        tq = {32'h00E00010, 32'h0460000F, 32'h03600000, 32'h03E00001,
            32'h03E00004, 32'h06E00002, 32'h00000000};
        host.xfer(1'b1, REG_CTRL, 32'h01);
        wt(1'b0);
        rd(REG_STATUS, 32'h2C);
        @(posedge clk_i);
        external_trigger_in_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        external_trigger_in_n_i <= 1'b1;
        wt(1'b1);
        rd(REG_STATUS, 32'h21);
        host.xfer(1'b1, REG_CTRL, 32'h20);
        rd(REG_STATUS, 32'h21);
        $display("test run done");
        external_restart_in_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        external_restart_in_n_i <= 1'b1;
        rd(REG_STATUS, 32'h22);
        tq = {32'h00E00010, 32'h00000000, 32'h00E00010, 32'h00000000};
        host.xfer(1'b1, REG_CTRL, 32'h20);
        host.xfer(1'b1, REG_CTRL, 32'h02);
        chk({8'h00, ttl_o}, 32'h00E00010);
        host.xfer(1'b1, REG_CTRL, 32'h04);
        host.xfer(1'b1, REG_CONFIG, 32'h1);
        host.xfer(1'b1, REG_CTRL, 32'h20);
        host.xfer(1'b1, REG_CTRL, 32'h02);
        for (int i = 0; i < 50 && tq.size() > 0; i++) @(posedge clk_i);
        chk(tq.size(), 32'h0);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(REG_STATUS, 32'h2);
        $display("test stop done");
        summarize();
    end
endmodule // pulse_program_sequencer_tb
`default_nettype wire

// >>> testbench/pulse_seq_props.sv
// Purpose: Port checks for the pulse sequencer
// Assumes: One clock, synchronous active-high reset
// Notes: Attached by the bind below
`timescale 1ns/10ps
`default_nettype none
module pulse_seq_props
    import pulse_seq_pkg::*;
(
    // Clock, reset, bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // Pins and status
    input wire logic external_trigger_in_n_i,
    input wire logic external_restart_in_n_i,
    input wire logic [PAT_W-1:0] ttl_o,
    input wire logic stopped_o,
    input wire logic reset_state_o,
    input wire logic running_o,
    input wire logic waiting_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_short_on;
        $changed(ttl_o) && ttl_o[23:21] == TRIPLE_CYCLE_PULSE_CODE
            && ttl_o[20:0] != 21'h0;
    endsequence
    sequence s_short_off;
        $stable(ttl_o)[*2] ##1 ttl_o[20:0] == 21'h0;
    endsequence
    property p_triple;
        s_short_on |=> s_short_off;
    endproperty
    a_triple: assert property (p_triple)
        else $error("short pulse not three cycles");
    property p_full;
        $changed(ttl_o) && ttl_o[23:21] == SHORT_OFF |=> $stable(ttl_o);
    endproperty
    a_full: assert property (p_full)
        else $error("full pulse cut short");
    property p_wait_run;
        waiting_o |-> running_o;
    endproperty
    a_wait_run: assert property (p_wait_run)
        else $error("waiting without running");
    property p_stop_stat;
        $rose(stopped_o) |-> $past(running_o) && !running_o;
    endproperty
    a_stop_stat: assert property (p_stop_stat)
        else $error("stopped not entered from execution");
    property p_restart;
        !external_restart_in_n_i |=> reset_state_o && !running_o;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart pin ignored");
    property p_resume;
        waiting_o && $fell(external_trigger_in_n_i) |-> ##[1:3] !waiting_o;
    endproperty
    a_resume: assert property (p_resume)
        else $error("trigger did not resume");
    property p_ack_resp;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("bus answer late");
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
endmodule // pulse_seq_props
bind pulse_program_sequencer pulse_seq_props u_props (.clk_i, .rst_i,
    .cyc_i, .stb_i, .ack_o, .external_trigger_in_n_i,
    .external_restart_in_n_i, .ttl_o, .stopped_o, .reset_state_o,
    .running_o, .waiting_o);
`default_nettype wire
